// ---- core/tx_redundancy_ctrl.sv ----
// Purpose: Transmit output gating, 1+1 redundancy switching and
//          legacy binary command decoding.
// Assumes: Wishbone classic slave; rx bytes come from a UART on core_clk.
// Notes:   Fault pins are synchronised; other inputs are on core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "txr_map.svh"

module tx_redundancy_ctrl
	import txr_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `ONE_SEC_NS / `CLK_PERIOD_NS,
	parameter int unsigned GAP_CYCLES = `BYTE_GAP_NS / `CLK_PERIOD_NS
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic unit_fault_pin,
	input wire logic partner_fault_pin,
	input wire logic [7:0] temp_c,
	input wire logic [15:0] power_sample,
	input wire logic sample_valid,
	input wire logic burst_valid,
	output logic tx_on,
	output logic wg_switch_b,
	output logic clone_sync,
	output logic query_pulse,
	output var query_s query,
	output logic [8:0] resp_delay_ms
);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int GW = $clog2(GAP_CYCLES + 1);

	// ==========================================================
	// Helpers
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] sel);
		merge16 = {sel[1] ? nw[15:8] : old[15:8],
			sel[0] ? nw[7:0] : old[7:0]};
	endfunction

	function automatic logic in_range(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	cfg_s cfg;
	pu_state_e pu_state;
	logic [1:0] fault_meta, fault_sync;
	logic [TW-1:0] tick_cnt;
	logic sec_tick;
	logic [8:0] elapsed, mute_delay;
	logic [7:0] attn, rdelay;
	logic [3:0] unit_addr;
	logic [15:0] freq, thresh, power_rd, ctrl_new;
	logic ot_alarm;
	logic [1:0] tx_state;
	logic [2:0] idx;
	logic [7:0] fb [0:5];
	logic [7:0] sum;
	logic [GW-1:0] gap_cnt;
	logic [31:0] rd_mux;

	// ==========================================================
	// Bus decode and shared terms
	logic wb_wr, sw_cmd, online, guard, major_fault, expire, in_delay;
	logic frame_end, frame_hit;
	logic [7:0] cmd, d1, d2;
	assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign sw_cmd = wb_wr && wb_adr_i == `REG_SWITCH && wb_sel_i[0];
	assign online = wg_switch_b == cfg.switch_port_position;
	assign guard = online | ~cfg.clone_enable;
	assign major_fault = fault_sync[0] | ot_alarm;
	assign in_delay = pu_state == PU_DELAY;
	assign expire = in_delay && elapsed >= mute_delay;
	assign ctrl_new = merge16({7'h00, cfg}, wb_dat_i[15:0], wb_sel_i[1:0]);
	assign cmd = fb[1];
	assign d1 = fb[2];
	assign d2 = fb[3];
	assign frame_end = rx_valid && idx == `FRAME_LAST;
	assign frame_hit = frame_end && rx_data == sum
		&& fb[0] == {4'h0, unit_addr};

	// ==========================================================
	// Fault pin synchroniser
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fault_meta <= 2'h0;
			fault_sync <= 2'h0;
		end else begin
			fault_meta <= {partner_fault_pin, unit_fault_pin};
			fault_sync <= fault_meta;
		end
	end

	// ==========================================================
	// Power-up delay
	// one-second tick
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tick_cnt <= '0;
			sec_tick <= 1'b0;
		end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
			tick_cnt <= '0;
			sec_tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			sec_tick <= 1'b0;
		end
	end

	// Elapsed count meets mute_delay, reset to 0, on the first clock after reset, so the delay ends then
	// delay count-up
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pu_state <= PU_DELAY;
			elapsed <= 9'h000;
		end else begin
			case (pu_state)
				PU_DELAY: begin
					if (expire) begin
						pu_state <= PU_RUN;
					end else if (sec_tick) begin
						elapsed <= elapsed + 1'b1;
					end
				end
				PU_RUN: pu_state <= PU_RUN;
				default: pu_state <= PU_DELAY;
			endcase
		end
	end

	// ==========================================================
	// Control word
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg <= cfg_s'(`CTRL_RESET);
		end else begin
			if (expire) begin
				cfg.tx_output_enable <= cfg.powerup_tx_state;
			end
			if (frame_hit && guard && cmd == `CMD_TX) begin
				case (d1[1:0])
					2'h0: cfg.tx_output_enable <= 1'b0;
					2'h1: cfg.tx_output_enable <= 1'b1;
					2'h2: cfg.powerup_tx_state <= 1'b0;
					default: cfg.powerup_tx_state <= 1'b1;
				endcase
			end
			if (wb_wr && wb_adr_i == `REG_CTRL) begin
				cfg.switch_port_position <= ctrl_new[5];
				if (guard) begin
					cfg.powerup_tx_state <= ctrl_new[0];
					cfg.tx_output_enable <= ctrl_new[1];
					cfg.overtemp_shutdown_enable <= ctrl_new[2];
					cfg.power_monitor_mode <= ctrl_new[3];
					cfg.legacy_protocol_select <= ctrl_new[8];
				end
				if (online) begin
					cfg.revert_mode <= ctrl_new[4];
					cfg.clone_enable <= ctrl_new[6];
					cfg.switching_type <= ctrl_new[7];
				end
			end
		end
	end

	// ==========================================================
	// Numeric settings
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mute_delay <= `DELAY_RESET;
			attn <= `ATTEN_RESET;
			unit_addr <= `ADDR_RESET;
			rdelay <= `RDELAY_RESET;
			freq <= `FREQ_RESET;
			thresh <= `THRESH_RESET;
		end else begin
			if (frame_hit) begin
				case (cmd)
					`CMD_ADDR: begin
						if (in_range(d1, `ADDR_MIN, `ADDR_MAX)) begin
							unit_addr <= d1[3:0];
						end
						if (d2 != `FILLER) begin
							rdelay <= d2;
						end
					end
					`CMD_FREQ: if (guard) freq <= {d1, d2};
					`CMD_THRESH: if (guard) thresh <= {d1, d2};
					`CMD_GAIN: begin
						if (in_range(d2, `ADDR_MIN, `ADDR_MAX)) begin
							attn <= 8'(d2 * `GAIN_STEP);
						end
					end
					default: attn <= attn;
				endcase
			end
			if (wb_wr) begin
				case (wb_adr_i)
					`REG_DELAY: begin
						if (guard && wb_dat_i[8:0] <= `DELAY_MAX) begin
							mute_delay <= wb_dat_i[8:0];
						end
					end
					`REG_ATTEN: begin
						if (wb_dat_i[7:0] <= `ATTEN_MAX) begin
							attn <= wb_dat_i[7:0];
						end
					end
					`REG_LINK: begin
						if (in_range({4'h0, wb_dat_i[3:0]},
							`ADDR_MIN, `ADDR_MAX)) begin
							unit_addr <= wb_dat_i[3:0];
						end
						rdelay <= wb_dat_i[15:8];
					end
					`REG_FREQ: if (guard) freq <= wb_dat_i[15:0];
					`REG_THRESH: thresh <= wb_dat_i[15:0];
					default: rdelay <= rdelay;
				endcase
			end
		end
	end

	// ==========================================================
	// Waveguide switch
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wg_switch_b <= 1'b0;
		end else if (sw_cmd) begin
			wg_switch_b <= wb_dat_i[0];
		end else if (cfg.switching_type && online && major_fault
			&& !fault_sync[1]) begin
			if (!cfg.revert_mode || !wg_switch_b) begin
				wg_switch_b <= ~wg_switch_b;
			end
		end
	end

	// ==========================================================
	// Output gating and monitoring
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ot_alarm <= 1'b0;
			tx_on <= 1'b0;
			tx_state <= 2'h0;
			clone_sync <= 1'b0;
			resp_delay_ms <= 9'h000;
		end else begin
			ot_alarm <= cfg.overtemp_shutdown_enable
				&& $signed(temp_c) >= $signed(`OVERTEMP_C);
			tx_on <= !in_delay && cfg.tx_output_enable && !major_fault;
			if (!cfg.tx_output_enable) begin
				tx_state <= 2'h0;
			end else if (in_delay || major_fault) begin
				tx_state <= 2'h2;
			end else begin
				tx_state <= 2'h1;
			end
			clone_sync <= sec_tick && cfg.clone_enable && online;
			resp_delay_ms <= (rdelay == 8'h00) ? `RDELAY_ZERO_MS
				: {1'b0, rdelay};
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			power_rd <= 16'h0000;
		end else if (sample_valid
			&& (!cfg.power_monitor_mode || burst_valid)) begin
			power_rd <= power_sample;
		end
	end

	// ==========================================================
	// Legacy frame receiver
	// Gap timeout resyncs a host that abandoned a frame mid-way
	// byte collection
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			idx <= 3'h0;
			sum <= 8'h00;
			gap_cnt <= '0;
			for (int i = 0; i < 6; i++) begin
				fb[i] <= 8'h00;
			end
		end else if (!cfg.legacy_protocol_select) begin
			idx <= 3'h0;
			gap_cnt <= '0;
		end else if (rx_valid) begin
			gap_cnt <= '0;
			if (frame_end) begin
				idx <= 3'h0;
			end else begin
				fb[idx] <= rx_data;
				sum <= (idx == 3'h0) ? rx_data : sum + rx_data;
				idx <= idx + 1'b1;
			end
		end else if (idx != 3'h0) begin
			if (gap_cnt == GW'(GAP_CYCLES - 1)) begin
				idx <= 3'h0;
				gap_cnt <= '0;
			end else begin
				gap_cnt <= gap_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			query_pulse <= 1'b0;
			query <= '0;
		end else begin
			query_pulse <= frame_hit && (cmd == `CMD_STATUS
				|| cmd == `CMD_BURST || cmd == `CMD_TYPE
				|| cmd == `CMD_TEMP);
			if (frame_hit) begin
				query <= '{cmd: cmd, sel: d1};
			end
		end
	end

	// ==========================================================
	// Wishbone slave
	always_comb begin
		case (wb_adr_i)
			`REG_CTRL: rd_mux = {23'h0, cfg};
			`REG_DELAY: rd_mux = {23'h0, mute_delay};
			`REG_ATTEN: rd_mux = {24'h0, attn};
			`REG_SWITCH: rd_mux = {31'h0, wg_switch_b};
			`REG_STATUS: rd_mux = {24'h0, tx_state, online, ot_alarm,
				fault_sync, wg_switch_b, !in_delay};
			`REG_POWER: rd_mux = {16'h0, power_rd};
			`REG_LINK: rd_mux = {16'h0, rdelay, 4'h0, unit_addr};
			`REG_FREQ: rd_mux = {16'h0, freq};
			`REG_THRESH: rd_mux = {16'h0, thresh};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= rd_mux;
		end
	end

	// ==========================================================
	// Checks
	// muted in delay
	a_mute_hold: assert property (
		@(posedge core_clk) disable iff (rst) in_delay |=> !tx_on)
		else $error("output on during power-up delay");
	a_fault_blocks: assert property (
		@(posedge core_clk) disable iff (rst) fault_sync[0] |=> !tx_on)
		else $error("output on with fault");
	a_state_report: assert property (
		@(posedge core_clk) disable iff (rst) tx_on == (tx_state == 2'h1))
		else $error("state report disagrees with output");
	a_overtemp_mute: assert property (
		@(posedge core_clk) disable iff (rst)
		(cfg.overtemp_shutdown_enable
		&& $signed(temp_c) >= $signed(`OVERTEMP_C)) |-> ##2 !tx_on)
		else $error("output on at overtemp");
	a_standby_mode: assert property (
		@(posedge core_clk) disable iff (rst)
		(wb_wr && wb_adr_i == `REG_CTRL && !online)
		|=> $stable(cfg.revert_mode))
		else $error("mode changed on standby");
	a_manual_hold: assert property (
		@(posedge core_clk) disable iff (rst)
		(!cfg.switching_type && !sw_cmd) |=> $stable(wg_switch_b))
		else $error("switch moved in manual");
	a_auto_switch: assert property (
		@(posedge core_clk) disable iff (rst)
		(cfg.switching_type && online && major_fault && !fault_sync[1]
		&& !cfg.revert_mode && !sw_cmd) |=> $changed(wg_switch_b))
		else $error("no switchover on fault");
	a_nonrevert_hold: assert property (
		@(posedge core_clk) disable iff (rst)
		(cfg.revert_mode && wg_switch_b && !sw_cmd) |=> wg_switch_b)
		else $error("left B in non-reverting mode");
	a_legacy_off: assert property (
		@(posedge core_clk) disable iff (rst)
		!cfg.legacy_protocol_select |=> idx == 3'h0)
		else $error("frame decode while legacy off");
	a_frame_addr: assert property (
		@(posedge core_clk) disable iff (rst)
		(frame_end && fb[0] != {4'h0, unit_addr}) |=> !query_pulse)
		else $error("answered foreign frame");
	a_wb_ack: assert property (
		@(posedge core_clk) disable iff (rst)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not single cycle");
endmodule
`default_nettype wire

// ---- core/txr_map.svh ----
// Purpose: Offsets, reset values and timing figures of the transmit
//          control block.
// Assumes: 40 MHz core clock.
// Notes:   Definitions only.
`ifndef TXR_MAP_SVH
`define TXR_MAP_SVH

// ==========================================================
// Register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_DELAY 8'h04
`define REG_ATTEN 8'h08
`define REG_SWITCH 8'h0C
`define REG_STATUS 8'h10
`define REG_POWER 8'h14
`define REG_LINK 8'h18
`define REG_FREQ 8'h1C
`define REG_THRESH 8'h20

// ==========================================================
// Reset values
`define CTRL_RESET 9'h1C7
`define DELAY_RESET 9'h000
`define ATTEN_RESET 8'h00
`define ADDR_RESET 4'h1
`define RDELAY_RESET 8'h01
`define FREQ_RESET 16'h0000
`define THRESH_RESET 16'h0000

// ==========================================================
// Limits and codes
`define DELAY_MAX 9'h1F4
`define ATTEN_MAX 8'hA0
`define GAIN_STEP 8'h0A
`define OVERTEMP_C 8'h55
`define ADDR_MIN 8'h01
`define ADDR_MAX 8'h0F
`define FILLER 8'hAA
`define RDELAY_ZERO_MS 9'h100
`define FRAME_LAST 3'h6
`define CMD_STATUS 8'h01
`define CMD_TX 8'h02
`define CMD_ADDR 8'h03
`define CMD_FREQ 8'h04
`define CMD_THRESH 8'h05
`define CMD_BURST 8'h06
`define CMD_TYPE 8'h07
`define CMD_TEMP 8'h09
`define CMD_GAIN 8'hFF

// ==========================================================
// Timing
`define CLK_PERIOD_NS 25
`define ONE_SEC_NS 1000000000
`define BYTE_GAP_NS 10000000

`endif

// ---- core/txr_pkg.sv ----
// Purpose: Types shared by the transmit control block.
// Assumes: Nothing.
// Notes:   Struct order fixes the control word bit layout, bit 0 last.
package txr_pkg;
	typedef struct packed {
		logic legacy_protocol_select;
		logic switching_type;
		logic clone_enable;
		logic switch_port_position;
		logic revert_mode;
		logic power_monitor_mode;
		logic overtemp_shutdown_enable;
		logic tx_output_enable;
		logic powerup_tx_state;
	} cfg_s;

	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] sel;
	} query_s;

	typedef enum logic {
		PU_DELAY = 1'b0,
		PU_RUN = 1'b1
	} pu_state_e;
endpackage

// ---- verification/mc_host_model.sv ----
// Purpose: Monitor and control host that sends legacy command frames.
// Assumes: One byte per one-cycle rx_valid pulse on core_clk.
// Notes:   Between bytes the data lines show the inverse of the last byte.
`timescale 1ns/100ps
`default_nettype none
module mc_host_model (
	input wire logic core_clk,
	output logic rx_valid,
	output logic [7:0] rx_data
);
	// ==========================================================
	// Byte and frame sender
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end

	task automatic put(input logic [7:0] b);
		@(posedge core_clk);
		rx_valid <= 1'b1;
		rx_data <= b;
		@(posedge core_clk);
		rx_valid <= 1'b0;
		// Idle lines must not keep a stale byte
		rx_data <= ~b;
	endtask

	task automatic send(input logic [7:0] a, input logic [7:0] c,
		input logic [7:0] d1, input logic [7:0] d2, input logic bad);
		logic [7:0] s;
		s = a + c + d1 + d2 + 8'hAA + 8'hAA;
		put(a);
		put(c);
		put(d1);
		put(d2);
		put(8'hAA);
		put(8'hAA);
		put(bad ? ~s : s);
	endtask
endmodule
`default_nettype wire

// ---- verification/tb_tx_output_redundancy_command_logic.sv ----
// Purpose: Self-checking bench for the transmit control block.
// Assumes: Short one-second tick (20 cycles) and byte gap (50 cycles).
// Notes:   Waits of 8 cycles cover the 2FF fault sync plus output register.
`timescale 1ns/100ps
`default_nettype none
`include "txr_map.svh"
module tb_tx_output_redundancy_command_logic;
	// ==========================================================
	// Signals
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] dat_o;
	logic ack;
	logic rxv;
	logic [7:0] rxd;
	logic ufault = 1'b0;
	logic pfault = 1'b0;
	logic [7:0] temp = 8'h19;
	logic [15:0] psamp = 16'h0000;
	logic svalid = 1'b0;
	logic bvalid = 1'b0;
	logic tx_on;
	logic wg;
	logic csync;
	logic qp;
	logic [15:0] query;
	logic [8:0] rdelay;
	int num_errors = 0;
	int samples_checked = 0;
	int qn = 0;

	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (qp === 1'b1) qn <= qn + 1;

	tx_redundancy_ctrl #(.TICK_CYCLES(20), .GAP_CYCLES(50)) u_dut (
		.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .rx_valid(rxv), .rx_data(rxd),
		.unit_fault_pin(ufault), .partner_fault_pin(pfault), .temp_c(temp),
		.power_sample(psamp), .sample_valid(svalid), .burst_valid(bvalid),
		.tx_on(tx_on), .wg_switch_b(wg), .clone_sync(csync),
		.query_pulse(qp), .query(query), .resp_delay_ms(rdelay));
	mc_host_model u_host (.core_clk(core_clk), .rx_valid(rxv), .rx_data(rxd));

	// ==========================================================
	// Shared tasks
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask

	task pin(input string n, input logic e, input logic g);
		chk(n, {31'h0, e}, {31'h0, g});
	endtask

	task st;
		repeat (8) @(posedge core_clk);
	endtask

	// One power sample pulse, optionally qualified as a burst
	task smp(input logic [15:0] v, input logic b);
		@(posedge core_clk);
		psamp <= v;
		bvalid <= b;
		svalid <= 1'b1;
		@(posedge core_clk);
		svalid <= 1'b0;
		bvalid <= 1'b0;
	endtask

	task wbx(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = dat_o;
		pin("wb_ack_o", 1'b1, ack);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wbx(1'b1, a, d, q);
	endtask

	task rdc(input string n, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] q;
		wbx(1'b0, a, 32'h0, q);
		chk(n, e, q & m);
	endtask

	// Counts query pulses over one frame; settings land by the return
	task fr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d1,
		input logic [7:0] d2, input logic bad, input logic [31:0] dq);
		int q0;
		q0 = qn;
		u_host.send(a, c, d1, d2, bad);
		repeat (3) @(posedge core_clk);
		chk("query_pulse count", dq, 32'(qn - q0));
	endtask

	task end_sim;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task t_reset;
		rdc("ctrl", `REG_CTRL, 32'h1FF, 32'h1C7);
		rdc("link", `REG_LINK, 32'hFF0F, 32'h0101);
		rdc("delay", `REG_DELAY, 32'h1FF, 32'h0);
		rdc("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
		pin("tx_on", 1'b1, tx_on);
		chk("resp_delay_ms", 32'h1, {23'h0, rdelay});
	endtask

	task t_switch;
		ufault <= 1'b1;
		st();
		pin("wg_switch_b", 1'b1, wg);
		ufault <= 1'b0;
		wr(`REG_CTRL, 32'h1D7);
		rdc("ctrl standby", `REG_CTRL, 32'h1FF, 32'h1C7);
		wr(`REG_CTRL, 32'h1C5);
		rdc("ctrl clone", `REG_CTRL, 32'h1FF, 32'h1C7);
		wr(`REG_SWITCH, 32'h0);
		st();
		pin("wg_switch_b", 1'b0, wg);
		wr(`REG_CTRL, 32'h1D7);
		rdc("ctrl online", `REG_CTRL, 32'h1FF, 32'h1D7);
		ufault <= 1'b1;
		st();
		pin("wg_switch_b", 1'b1, wg);
		ufault <= 1'b0;
		wr(`REG_CTRL, 32'h1F7);
		ufault <= 1'b1;
		st();
		pin("wg_switch_b", 1'b1, wg);
		ufault <= 1'b0;
		wr(`REG_CTRL, 32'h1D7);
		wr(`REG_SWITCH, 32'h0);
		wr(`REG_CTRL, 32'h1C7);
		ufault <= 1'b1;
		pfault <= 1'b1;
		st();
		pin("wg_switch_b", 1'b0, wg);
		ufault <= 1'b0;
		pfault <= 1'b0;
		wr(`REG_CTRL, 32'h147);
		ufault <= 1'b1;
		st();
		pin("wg_switch_b", 1'b0, wg);
		ufault <= 1'b0;
		wr(`REG_SWITCH, 32'h1);
		st();
		pin("wg_switch_b", 1'b1, wg);
		wr(`REG_SWITCH, 32'h0);
		wr(`REG_CTRL, 32'h1E7);
		st();
		pin("wg_switch_b", 1'b0, wg);
		wr(`REG_CTRL, 32'h1C7);
	endtask

	// Manual type keeps overtemp from moving the switch here
	task t_txen;
		wr(`REG_CTRL, 32'h1C5);
		st();
		pin("tx_on", 1'b0, tx_on);
		rdc("tx state", `REG_STATUS, 32'hC0, 32'h00);
		wr(`REG_CTRL, 32'h147);
		st();
		rdc("tx state", `REG_STATUS, 32'hC0, 32'h40);
		temp <= `OVERTEMP_C;
		st();
		pin("tx_on", 1'b0, tx_on);
		rdc("tx state", `REG_STATUS, 32'hC0, 32'h80);
		temp <= 8'h54;
		st();
		pin("tx_on", 1'b1, tx_on);
		temp <= `OVERTEMP_C;
		wr(`REG_CTRL, 32'h143);
		st();
		pin("tx_on", 1'b1, tx_on);
		temp <= 8'h19;
		wr(`REG_CTRL, 32'h1C7);
	endtask

	task t_atten;
		wr(`REG_ATTEN, 32'hA0);
		rdc("atten", `REG_ATTEN, 32'hFF, 32'hA0);
		wr(`REG_ATTEN, 32'hA1);
		rdc("atten", `REG_ATTEN, 32'hFF, 32'hA0);
		wr(`REG_DELAY, 32'h1F4);
		rdc("delay", `REG_DELAY, 32'h1FF, 32'h1F4);
		wr(`REG_DELAY, 32'h1F5);
		rdc("delay", `REG_DELAY, 32'h1FF, 32'h1F4);
		// A delay set after expiry must not mute a running output
		pin("tx_on", 1'b1, tx_on);
	endtask

	// Burst mode keeps the last qualified sample only
	task t_power;
		smp(16'h1234, 1'b0);
		rdc("power", `REG_POWER, 32'hFFFF, 32'h1234);
		wr(`REG_CTRL, 32'h1CF);
		smp(16'h5678, 1'b0);
		rdc("power burst", `REG_POWER, 32'hFFFF, 32'h1234);
		smp(16'h9ABC, 1'b1);
		rdc("power burst", `REG_POWER, 32'hFFFF, 32'h9ABC);
		wr(`REG_CTRL, 32'h1C7);
	endtask

	task automatic t_legacy;
		logic [7:0] c [4] = '{8'h01, 8'h06, 8'h07, 8'h09};
		logic [7:0] s [4] = '{8'hAA, 8'h01, 8'h00, 8'h00};
		for (int i = 0; i < 4; i++) begin
			fr(8'h01, c[i], s[i], 8'hAA, 1'b0, 32'h1);
			chk("query", {16'h0, c[i], s[i]}, {16'h0, query});
		end
		fr(8'h01, 8'h01, 8'hAA, 8'hAA, 1'b1, 32'h0);
		fr(8'h02, 8'h01, 8'hAA, 8'hAA, 1'b0, 32'h0);
		fr(8'h01, 8'h02, 8'h00, 8'hAA, 1'b0, 32'h0);
		st();
		pin("tx_on", 1'b0, tx_on);
		fr(8'h01, 8'h02, 8'h01, 8'hAA, 1'b0, 32'h0);
		st();
		pin("tx_on", 1'b1, tx_on);
		fr(8'h01, 8'h02, 8'h02, 8'hAA, 1'b0, 32'h0);
		rdc("ctrl", `REG_CTRL, 32'h1FF, 32'h1C6);
		fr(8'h01, 8'h02, 8'h03, 8'hAA, 1'b0, 32'h0);
		rdc("ctrl", `REG_CTRL, 32'h1FF, 32'h1C7);
		fr(8'h01, 8'h04, 8'h12, 8'h34, 1'b0, 32'h0);
		rdc("freq", `REG_FREQ, 32'hFFFF, 32'h1234);
		fr(8'h01, 8'h05, 8'h56, 8'h78, 1'b0, 32'h0);
		rdc("thresh", `REG_THRESH, 32'hFFFF, 32'h5678);
		fr(8'h01, 8'hFF, 8'hAA, 8'h03, 1'b0, 32'h0);
		rdc("atten", `REG_ATTEN, 32'hFF, 32'h1E);
		fr(8'h01, 8'h03, 8'h05, 8'h00, 1'b0, 32'h0);
		chk("resp_delay_ms", 32'h100, {23'h0, rdelay});
		rdc("link addr", `REG_LINK, 32'hF, 32'h5);
		fr(8'h05, 8'h03, 8'h05, 8'hAA, 1'b0, 32'h0);
		chk("resp_delay_ms", 32'h100, {23'h0, rdelay});
		wr(`REG_CTRL, 32'h0C7);
		fr(8'h05, 8'h01, 8'hAA, 8'hAA, 1'b0, 32'h0);
		wr(`REG_CTRL, 32'h1C7);
	endtask

	// Three ticks of 20 cycles give two or three pulses
	task t_clone;
		int n;
		n = 0;
		repeat (60) begin
			@(posedge core_clk);
			if (csync === 1'b1) n++;
		end
		pin("clone_sync", 1'b1, n >= 2 && n <= 3);
		wr(`REG_CTRL, 32'h187);
		n = 0;
		repeat (60) begin
			@(posedge core_clk);
			if (csync === 1'b1) n++;
		end
		chk("clone_sync off", 32'h0, 32'(n));
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_switch();
		t_txen();
		t_atten();
		t_legacy();
		t_power();
		t_clone();
		end_sim();
	end

	initial begin
		#1000000;
		num_errors++;
		end_sim();
	end
endmodule
`default_nettype wire
